/* File: freq_ref_pkg.sv */
// constants, types and carriers for the frequency reference selector
package freq_ref_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned REF_W  = 16;
  localparam int unsigned ADC_W  = 12;
  localparam int unsigned STEPS  = 17;
  localparam int unsigned JOG_STEP = 16;

  // register byte offsets
  localparam logic [7:0] OFF_SRC_SEL    = 8'h00;
  localparam logic [7:0] OFF_PULSE_FN   = 8'h04;
  localparam logic [7:0] OFF_FULL_SCALE = 8'h08;
  localparam logic [7:0] OFF_ANALOG_CFG = 8'h0c;
  localparam logic [7:0] OFF_STATUS     = 8'h10;
  localparam logic [7:0] OFF_REF_OUT    = 8'h14;
  localparam logic [7:0] OFF_PULSE_HZ   = 8'h18;
  localparam logic [7:0] OFF_TABLE      = 8'h40;

  // field positions in the analog configuration register
  localparam int unsigned ACFG_FN_LSB   = 0;
  localparam int unsigned ACFG_SWAP_BIT = 8;

  // reset values and ranges
  localparam logic [15:0] SRC_SEL_RST    = 16'h0001;
  localparam logic [15:0] SRC_SEL_MAX    = 16'h0004;
  localparam logic [15:0] PULSE_FN_RST   = 16'h0000;
  localparam logic [15:0] PULSE_FN_MAX   = 16'h0002;
  localparam logic [15:0] FULL_SCALE_RST = 16'h05a0;
  localparam logic [15:0] FULL_SCALE_MIN = 16'h03e8;
  localparam logic [15:0] FULL_SCALE_MAX = 16'h7d00;
  localparam logic [4:0]  A2_FN_ADD      = 5'h00;
  localparam logic [4:0]  A2_FN_AUX      = 5'h02;

  // reference units are 0.01 %; this is 100 %
  localparam logic [15:0] REF_FULL = 16'h2710;

  // analog current span 4 to 20 mA; the converter's full range is 0 to 20 mA
  localparam int unsigned CUR_ZERO_MA = 4;
  localparam int unsigned CUR_FULL_MA = 20;
  localparam int unsigned ADC_FS      = 1 << ADC_W;
  localparam int unsigned CUR_ZERO_CODE = ADC_FS * CUR_ZERO_MA / CUR_FULL_MA;
  localparam int unsigned CUR_SPAN_CODE = ADC_FS - CUR_ZERO_CODE;

  // pulse measurement gate
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned GATE_TIME_MS  = 100;
  localparam int unsigned GATE_CYCLES   = GATE_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int unsigned HZ_PER_COUNT  = 1000 / GATE_TIME_MS;
  localparam int unsigned DIV_STEPS     = 32;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [2:0] {
    SRC_PANEL  = 3'b000,
    SRC_ANALOG = 3'b001,
    SRC_SERIAL = 3'b010,
    SRC_OPTION = 3'b011,
    SRC_PULSE  = 3'b100
  } ref_src_t;

  typedef enum logic [1:0] {
    PFN_FREQ   = 2'b00,
    PFN_PID_FB = 2'b01,
    PFN_PID_SP = 2'b10
  } pulse_fn_t;

  typedef enum logic {
    DIV_IDLE = 1'b0,
    DIV_RUN  = 1'b1
  } div_state_t;

  typedef struct packed {
    logic jog_select_input;
    logic multistep_command_three;
    logic multistep_command_two;
    logic multistep_command_one_input;
  } contact_in_t;

  typedef struct packed {
    logic [ADC_W-1:0] first_analog_input;
    logic [ADC_W-1:0] second_analog_input;
    logic             second_analog_current;
  } analog_in_t;

  typedef struct packed {
    logic [REF_W-1:0] freq_ref;
    logic [REF_W-1:0] pid_feedback;
    logic [REF_W-1:0] pid_target;
  } ref_out_t;
endpackage

/* File: freq_ref_selector.sv */
// frequency reference source selector with AXI4-Lite register access
//
// Our own choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module freq_ref_selector #(
  parameter int unsigned GATE_LEN = freq_ref_pkg::GATE_CYCLES
) (
  input  wire logic                                  clk,
  input  wire logic                                  rst_n,
  input  wire logic                                  awvalid,
  output logic                                       awready,
  input  wire logic [freq_ref_pkg::ADDR_W-1:0]       awaddr,
  input  wire logic                                  wvalid,
  output logic                                       wready,
  input  wire logic [freq_ref_pkg::DATA_W-1:0]       wdata,
  input  wire logic [3:0]                            wstrb,
  output logic                                       bvalid,
  input  wire logic                                  bready,
  output logic [1:0]                                 bresp,
  input  wire logic                                  arvalid,
  output logic                                       arready,
  input  wire logic [freq_ref_pkg::ADDR_W-1:0]       araddr,
  output logic                                       rvalid,
  input  wire logic                                  rready,
  output logic [freq_ref_pkg::DATA_W-1:0]            rdata,
  output logic [1:0]                                 rresp,
  input  wire logic                                  drive_running,
  input  wire logic [freq_ref_pkg::REF_W-1:0]        panel_ref,
  input  wire logic [freq_ref_pkg::REF_W-1:0]        vendor_serial_comms_ref,
  input  wire logic [freq_ref_pkg::REF_W-1:0]        option_card_ref,
  input  wire freq_ref_pkg::analog_in_t              analog_in,
  input  wire freq_ref_pkg::contact_in_t             contact_in,
  input  wire logic                                  pulse_train_input,
  output freq_ref_pkg::ref_out_t                     ref_out
);
  import freq_ref_pkg::*;

  if (GATE_LEN < 2) begin : g_bad_gate
    $error("gate length must be at least two cycles");
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // pin synchronisers: stage one feeds stage two only
  localparam int unsigned PIN_W = $bits(analog_in_t) + $bits(contact_in_t) + 1;
  logic [PIN_W-1:0] pin_s1_q;
  logic [PIN_W-1:0] pin_s2_q;
  analog_in_t       ana_s;
  contact_in_t      cin_s;
  logic             pulse_s;
  logic             pulse_prev_q;

  always_ff @(posedge clk) begin
    pin_s1_q <= {analog_in, contact_in, pulse_train_input};
    pin_s2_q <= pin_s1_q;
  end
  assign {ana_s, cin_s, pulse_s} = pin_s2_q;

  // configuration registers
  logic [15:0]   src_sel_q;
  logic [15:0]   pulse_fn_q;
  logic [15:0]   full_scale_q;
  logic [4:0]    a2_fn_q;
  logic          swap_q;
  ref_src_t      src_act_q;
  pulse_fn_t     pfn_act_q;
  logic [15:0]   table_q [STEPS];

  // AXI4-Lite write side
  logic              aw_hold_q;
  logic              w_hold_q;
  logic [7:0]        aw_addr_q;
  logic [31:0]       w_data_q;
  logic [3:0]        w_strb_q;
  logic              do_write;
  logic              aw_hold_d;
  logic              w_hold_d;
  logic              bvalid_d;
  logic [31:0]       wmask;
  logic              wr_err;
  logic [4:0]        wr_idx;
  logic              wr_tbl;

  assign do_write  = aw_hold_q & w_hold_q & ~bvalid;
  assign aw_hold_d = (aw_hold_q | (awvalid & awready)) & ~do_write;
  assign w_hold_d  = (w_hold_q | (wvalid & wready)) & ~do_write;
  assign bvalid_d  = do_write | (bvalid & ~bready);
  assign wmask     = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}, {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
  assign wr_idx    = 5'((aw_addr_q - OFF_TABLE) >> 2);
  assign wr_tbl    = (aw_addr_q >= OFF_TABLE) && (wr_idx < 5'(STEPS));

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [31:0] m);
    merge16 = (old & ~m[15:0]) | (d[15:0] & m[15:0]);
  endfunction

  logic [15:0] src_new;
  logic [15:0] pfn_new;
  logic [15:0] fs_new;
  assign src_new = merge16(src_sel_q, w_data_q, wmask);
  assign pfn_new = merge16(pulse_fn_q, w_data_q, wmask);
  assign fs_new  = merge16(full_scale_q, w_data_q, wmask);

  always_comb begin
    wr_err = 1'b0;
    unique case (aw_addr_q)
      OFF_SRC_SEL:    wr_err = src_new > SRC_SEL_MAX;
      OFF_PULSE_FN:   wr_err = pfn_new > PULSE_FN_MAX;
      OFF_FULL_SCALE: wr_err = (fs_new < FULL_SCALE_MIN) || (fs_new > FULL_SCALE_MAX);
      OFF_ANALOG_CFG: wr_err = 1'b0;
      default:        wr_err = ~wr_tbl;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      aw_hold_q <= 1'b0;
      w_hold_q  <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
      awready   <= 1'b0;
      wready    <= 1'b0;
      bvalid    <= 1'b0;
      bresp     <= RESP_OKAY;
    end else begin
      aw_hold_q <= aw_hold_d;
      w_hold_q  <= w_hold_d;
      awready   <= ~aw_hold_d & ~bvalid_d;
      wready    <= ~w_hold_d & ~bvalid_d;
      bvalid    <= bvalid_d;
      if (awvalid && awready) begin
        aw_addr_q <= awaddr;
      end
      if (wvalid && wready) begin
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end
      if (do_write) begin
        bresp <= wr_err ? RESP_SLVERR : RESP_OKAY;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      src_sel_q    <= SRC_SEL_RST;
      pulse_fn_q   <= PULSE_FN_RST;
      full_scale_q <= FULL_SCALE_RST;
      a2_fn_q      <= A2_FN_ADD;
      swap_q       <= 1'b0;
    end else if (do_write && !wr_err) begin
      unique case (aw_addr_q)
        OFF_SRC_SEL:    src_sel_q <= src_new;
        OFF_PULSE_FN:   pulse_fn_q <= pfn_new;
        OFF_FULL_SCALE: full_scale_q <= fs_new;
        OFF_ANALOG_CFG: begin
          if (w_strb_q[0]) a2_fn_q <= w_data_q[ACFG_FN_LSB +: 5];
          if (w_strb_q[1]) swap_q <= w_data_q[ACFG_SWAP_BIT];
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < STEPS; i++) table_q[i] <= 16'h0000;
    end else if (do_write && wr_tbl) begin
      table_q[wr_idx] <= merge16(table_q[wr_idx], w_data_q, wmask);
    end
  end

  // selectors take effect only while the drive is stopped
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      src_act_q <= SRC_ANALOG;
      pfn_act_q <= PFN_FREQ;
    end else if (!drive_running) begin
      src_act_q <= ref_src_t'(src_sel_q[2:0]);
      pfn_act_q <= pulse_fn_t'(pulse_fn_q[1:0]);
    end
  end

  // sampled rst_n in antecedents: the release edge still resets the flops
  property p_frozen;
    rst_n && drive_running |=> $stable(src_act_q) && $stable(pfn_act_q);
  endproperty
  a_frozen: assert property (p_frozen) else $error("selector changed while running");

  property p_src_range;
    src_sel_q <= SRC_SEL_MAX && pulse_fn_q <= PULSE_FN_MAX;
  endproperty
  a_src_range: assert property (p_src_range) else $error("selector out of range");

  property p_scale_range;
    full_scale_q >= FULL_SCALE_MIN && full_scale_q <= FULL_SCALE_MAX;
  endproperty
  a_scale_range: assert property (p_scale_range) else $error("scale out of range");

  // pulse frequency measurement: edges per gate, then divide by scale
  logic [31:0] gate_cnt_q;
  logic [15:0] edge_cnt_q;
  logic        gate_end;
  assign gate_end = gate_cnt_q == 32'(GATE_LEN - 1);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pulse_prev_q <= 1'b0;
      gate_cnt_q   <= 32'h0000_0000;
      edge_cnt_q   <= 16'h0000;
    end else begin
      pulse_prev_q <= pulse_s;
      gate_cnt_q   <= gate_end ? 32'h0000_0000 : gate_cnt_q + 32'h0000_0001;
      if (gate_end) begin
        // an edge on the closing cycle opens the next gate, so none is lost
        edge_cnt_q <= {15'h0000, pulse_s & ~pulse_prev_q};
      end else if (pulse_s && !pulse_prev_q && edge_cnt_q != 16'hffff) begin
        edge_cnt_q <= edge_cnt_q + 16'h0001;
      end
    end
  end

  div_state_t  div_st_q;
  logic [5:0]  div_cnt_q;
  logic [31:0] quo_q;
  logic [16:0] rem_q;
  logic [15:0] div_by_q;
  logic [15:0] pulse_hz_q;
  logic [15:0] pulse_pct_q;
  logic [16:0] rem_sh;
  logic [31:0] hz_full;
  logic [15:0] hz_sat;

  assign hz_full = 32'(edge_cnt_q) * 32'(HZ_PER_COUNT);
  assign hz_sat  = (hz_full > 32'h0000_ffff) ? 16'hffff : hz_full[15:0];
  assign rem_sh  = {rem_q[15:0], quo_q[31]};

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      div_st_q    <= DIV_IDLE;
      div_cnt_q   <= 6'h00;
      quo_q       <= 32'h0000_0000;
      rem_q       <= 17'h0_0000;
      div_by_q    <= FULL_SCALE_RST;
      pulse_hz_q  <= 16'h0000;
      pulse_pct_q <= 16'h0000;
    end else begin
      unique case (div_st_q)
        DIV_IDLE: if (gate_end) begin
          div_st_q   <= DIV_RUN;
          div_cnt_q  <= 6'h00;
          pulse_hz_q <= hz_sat;
          quo_q      <= 32'(hz_sat) * 32'(REF_FULL);
          rem_q      <= 17'h0_0000;
          div_by_q   <= full_scale_q;
        end
        DIV_RUN: begin
          if (rem_sh >= {1'b0, div_by_q}) begin
            rem_q <= rem_sh - {1'b0, div_by_q};
            quo_q <= {quo_q[30:0], 1'b1};
          end else begin
            rem_q <= rem_sh;
            quo_q <= {quo_q[30:0], 1'b0};
          end
          div_cnt_q <= div_cnt_q + 6'h01;
          if (div_cnt_q == 6'(DIV_STEPS - 1)) begin
            div_st_q <= DIV_IDLE;
          end
        end
      endcase
      if (div_st_q == DIV_IDLE && div_cnt_q == 6'(DIV_STEPS)) begin
        pulse_pct_q <= (quo_q > 32'(REF_FULL)) ? REF_FULL : quo_q[15:0];
        div_cnt_q   <= 6'h00;
      end
    end
  end

  sequence s_div_launch;
    div_st_q == DIV_IDLE && gate_end;
  endsequence
  sequence s_div_finish;
    div_st_q == DIV_IDLE && div_cnt_q == 6'h20;
  endsequence
  property p_div_time;
    s_div_launch |-> ##33 s_div_finish;
  endproperty
  a_div_time: assert property (p_div_time) else $error("divide did not finish on time");

  property p_pct_sat;
    pulse_pct_q <= REF_FULL;
  endproperty
  a_pct_sat: assert property (p_pct_sat) else $error("pulse reference above full");

  // analog scaling to 0.01 % units
  logic [15:0] a1_pct;
  logic [15:0] a2_volt;
  logic [15:0] a2_cur;
  logic [15:0] a2_pct;
  logic [15:0] master_pct;
  logic [15:0] aux_pct;
  logic [16:0] sum_raw;
  logic [15:0] sum_pct;
  logic [27:0] cur_num;

  assign a1_pct  = 16'((28'(ana_s.first_analog_input) * 28'(REF_FULL)) >> ADC_W);
  assign a2_volt = 16'((28'(ana_s.second_analog_input) * 28'(REF_FULL)) >> ADC_W);
  assign cur_num = (28'(ana_s.second_analog_input) - 28'(CUR_ZERO_CODE)) * 28'(REF_FULL);
  assign a2_cur  = (ana_s.second_analog_input <= 12'(CUR_ZERO_CODE)) ? 16'h0000 :
                   16'(cur_num / 28'(CUR_SPAN_CODE));
  assign a2_pct     = ana_s.second_analog_current ? a2_cur : a2_volt;
  assign master_pct = swap_q ? a2_pct : a1_pct;
  assign aux_pct    = swap_q ? a1_pct : a2_pct;
  assign sum_raw    = 17'(master_pct) + 17'(aux_pct);
  assign sum_pct    = (sum_raw > 17'(REF_FULL)) ? REF_FULL : sum_raw[15:0];

  // step index from contact inputs, jog wins
  logic [4:0]  step;
  logic [15:0] ref_d;
  assign step = cin_s.jog_select_input ? 5'(JOG_STEP) :
                {2'b00, cin_s.multistep_command_three, cin_s.multistep_command_two,
                 cin_s.multistep_command_one_input};

  always_comb begin
    ref_d = table_q[step];
    if (!cin_s.jog_select_input) begin
      unique case (src_act_q)
        SRC_PANEL:  if (step == 5'h00) ref_d = panel_ref;
        SRC_ANALOG: begin
          if (step == 5'h00) begin
            ref_d = (a2_fn_q == A2_FN_ADD) ? sum_pct : master_pct;
          end else if (step == 5'h01 && a2_fn_q == A2_FN_AUX) begin
            ref_d = aux_pct;
          end
        end
        SRC_SERIAL: ref_d = vendor_serial_comms_ref;
        SRC_OPTION: ref_d = option_card_ref;
        SRC_PULSE:  ref_d = (pfn_act_q == PFN_FREQ) ? pulse_pct_q : 16'h0000;
        default:    ref_d = table_q[step];
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ref_out <= '0;
    end else begin
      ref_out.freq_ref     <= ref_d;
      ref_out.pid_feedback <= (pfn_act_q == PFN_PID_FB) ? pulse_pct_q : 16'h0000;
      ref_out.pid_target   <= (pfn_act_q == PFN_PID_SP) ? pulse_pct_q : 16'h0000;
    end
  end

  property p_panel;
    rst_n && src_act_q == SRC_PANEL && step == 5'h00
      |=> ref_out.freq_ref == $past(panel_ref);
  endproperty
  a_panel: assert property (p_panel) else $error("panel value not selected");

  property p_aux;
    rst_n && src_act_q == SRC_ANALOG && step == 5'h01 && a2_fn_q == A2_FN_AUX
      |=> ref_out.freq_ref == $past(aux_pct);
  endproperty
  a_aux: assert property (p_aux) else $error("auxiliary input not selected");

  property p_add;
    rst_n && src_act_q == SRC_ANALOG && step == 5'h00 && a2_fn_q == A2_FN_ADD && !swap_q
      |=> ref_out.freq_ref == $past(sum_pct) && $past(sum_raw) >= 17'($past(a1_pct));
  endproperty
  a_add: assert property (p_add) else $error("analog sum wrong");

  property p_swap;
    swap_q |-> master_pct == a2_pct && aux_pct == a1_pct;
  endproperty
  a_swap: assert property (p_swap) else $error("terminal swap wrong");

  property p_jog;
    rst_n && cin_s.jog_select_input |=> ref_out.freq_ref == $past(table_q[16]);
  endproperty
  a_jog: assert property (p_jog) else $error("jog not given priority");

  property p_pulse;
    rst_n && src_act_q == SRC_PULSE && pfn_act_q == PFN_FREQ && step != 5'(JOG_STEP)
      |=> ref_out.freq_ref == $past(pulse_pct_q);
  endproperty
  a_pulse: assert property (p_pulse) else $error("pulse reference not selected");

  // AXI4-Lite read side
  logic        rvalid_d;
  logic [31:0] rd_mux;
  logic        rd_err;
  logic [4:0]  rd_idx;
  assign rvalid_d = (arvalid & arready) | (rvalid & ~rready);
  assign rd_idx   = 5'((araddr - OFF_TABLE) >> 2);

  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_err = 1'b0;
    unique case (araddr)
      OFF_SRC_SEL:    rd_mux = {16'h0000, src_sel_q};
      OFF_PULSE_FN:   rd_mux = {16'h0000, pulse_fn_q};
      OFF_FULL_SCALE: rd_mux = {16'h0000, full_scale_q};
      OFF_ANALOG_CFG: rd_mux = {23'h00_0000, swap_q, 3'h0, a2_fn_q};
      OFF_STATUS:     rd_mux = {20'h0_0000, step, drive_running, 1'b0, pfn_act_q, src_act_q};
      OFF_REF_OUT:    rd_mux = {16'h0000, ref_out.freq_ref};
      OFF_PULSE_HZ:   rd_mux = {pulse_pct_q, pulse_hz_q};
      default: begin
        if (araddr >= OFF_TABLE && rd_idx < 5'(STEPS)) begin
          rd_mux = {16'h0000, table_q[rd_idx]};
        end else begin
          rd_err = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= RESP_OKAY;
    end else begin
      arready <= ~rvalid_d;
      rvalid  <= rvalid_d;
      if (arvalid && arready) begin
        rdata <= rd_mux;
        rresp <= rd_err ? RESP_SLVERR : RESP_OKAY;
      end
    end
  end
endmodule // freq_ref_selector

/* File: pulse_source.sv */
// pulse train source standing in for the external speed-setting device
`timescale 1ns/100ps
module pulse_source (
  input  wire logic       clk,
  input  wire logic       en,
  input  wire logic [7:0] half,
  output logic            pulse_train_input
);
  logic [7:0] cnt_q;
  // line idles low outside a burst
  always_ff @(posedge clk) begin
    if (!en) begin
      cnt_q <= 8'h01;
      pulse_train_input <= 1'b0;
    end else if (cnt_q >= half) begin
      cnt_q <= 8'h01;
      pulse_train_input <= !pulse_train_input;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
endmodule // pulse_source

/* File: freq_ref_selector_test.sv */
// self-checking bench for the frequency reference selector
`timescale 1ns/100ps
module freq_ref_selector_test;
  import freq_ref_pkg::*;
  typedef struct packed {
    logic [2:0]  src;
    logic [15:0] cfg;
    contact_in_t ct;
    logic [15:0] exp;
  } row_t;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, pen = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0, drive_running = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00, half = 8'h04;
  logic [31:0] wdata = 32'h0000_0000, rdata, rd;
  logic [3:0]  wstrb = 4'hf;
  logic        awready, wready, bvalid, arready, rvalid, pulse_train_input;
  logic [1:0]  bresp, rresp, resp;
  logic [15:0] panel_ref = 16'h0d05, vendor_serial_comms_ref = 16'h04d2;
  logic [15:0] option_card_ref = 16'h162e;
  analog_in_t  analog_in = {12'h800, 12'h400, 1'b0};
  contact_in_t contact_in = 4'h0;
  ref_out_t    ref_out;
  int          errors = 0, checks = 0, cyc = 0;
  row_t        rows [10];

  freq_ref_selector #(.GATE_LEN(400)) DUT (.clk, .rst_n, .awvalid, .awready, .awaddr,
    .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready,
    .araddr, .rvalid, .rready, .rdata, .rresp, .drive_running, .panel_ref,
    .vendor_serial_comms_ref, .option_card_ref, .analog_in, .contact_in,
    .pulse_train_input, .ref_out);
  pulse_source P0 (.clk, .en(pen), .half, .pulse_train_input);

  always #5 clk = ~clk;

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      finish_test;
    end
  end

  task automatic finish_test;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    fork
      begin
        do @(posedge clk); while (!awready);
        awvalid <= 1'b0;
      end
      begin
        do @(posedge clk); while (!wready);
        wvalid <= 1'b0;
      end
    join
    do @(posedge clk); while (!bvalid);
    resp = bresp;
    bready <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rdr(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clk); while (!rvalid);
    rd = rdata;
    resp = rresp;
    rready <= 1'b0;
    @(posedge clk);
  endtask

  task automatic look(input logic [15:0] e);
    repeat (8) @(posedge clk);
    chk("freq_ref", {16'h0000, ref_out.freq_ref}, {16'h0000, e});
  endtask

  initial begin
    // analog codes 0x800 and 0x400 give 5000 and 2500
    rows[0] = '{SRC_PANEL, 16'h0000, 4'h0, 16'h0d05};
    rows[1] = '{SRC_PANEL, 16'h0000, 4'h1, 16'h0100};
    rows[2] = '{SRC_SERIAL, 16'h0000, 4'h0, 16'h04d2};
    rows[3] = '{SRC_OPTION, 16'h0000, 4'h0, 16'h162e};
    rows[4] = '{SRC_ANALOG, 16'h0000, 4'h0, 16'h1d4c};
    rows[5] = '{SRC_ANALOG, 16'h0001, 4'h0, 16'h1388};
    rows[6] = '{SRC_ANALOG, 16'h0002, 4'h1, 16'h09c4};
    rows[7] = '{SRC_ANALOG, 16'h0102, 4'h1, 16'h1388};
    rows[8] = '{SRC_ANALOG, 16'h0102, 4'h0, 16'h09c4};
    rows[9] = '{SRC_PANEL, 16'h0000, 4'h9, 16'h0777};
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rdr(OFF_SRC_SEL);
    chk("src reset", rd, 32'h0000_0001);
    rdr(OFF_PULSE_FN);
    chk("fn reset", rd, 32'h0000_0000);
    rdr(OFF_FULL_SCALE);
    chk("scale reset", rd, 32'h0000_05a0);
    $display("test reset done");
    wr(OFF_TABLE + 8'h04, 32'h0000_0100);
    wr(OFF_TABLE + 8'h40, 32'h0000_0777);
    foreach (rows[i]) begin
      wr(OFF_SRC_SEL, {29'h0000_0000, rows[i].src});
      wr(OFF_ANALOG_CFG, {16'h0000, rows[i].cfg});
      contact_in <= rows[i].ct;
      look(rows[i].exp);
    end
    $display("test table done");
    // 4 mA on the second terminal reads as zero
    wr(OFF_SRC_SEL, 32'h0000_0001);
    wr(OFF_ANALOG_CFG, 32'h0000_0002);
    analog_in <= {12'h800, 12'h333, 1'b1};
    contact_in <= 4'h1;
    look(16'h0000);
    contact_in <= 4'h0;
    $display("test current done");
    wr(OFF_SRC_SEL, 32'h0000_0005);
    chk("src range", resp, RESP_SLVERR);
    wr(OFF_PULSE_FN, 32'h0000_0003);
    chk("fn range", resp, RESP_SLVERR);
    wr(OFF_FULL_SCALE, 32'h0000_03e7);
    chk("scale range", resp, RESP_SLVERR);
    rdr(8'h30);
    chk("unmapped", resp, RESP_SLVERR);
    rdr(OFF_SRC_SEL);
    chk("src kept", rd, 32'h0000_0001);
    $display("test refusal done");
    wr(OFF_SRC_SEL, 32'h0000_0000);
    look(16'h0d05);
    drive_running <= 1'b1;
    wr(OFF_SRC_SEL, 32'h0000_0002);
    look(16'h0d05);
    drive_running <= 1'b0;
    look(16'h04d2);
    $display("test freeze done");
    wr(OFF_FULL_SCALE, 32'h0000_03e8);
    wr(OFF_SRC_SEL, 32'h0000_0004);
    pen <= 1'b1;
    repeat (1000) @(posedge clk);
    chk("pulse", ref_out.freq_ref, 16'h1388);
    drive_running <= 1'b1;
    wr(OFF_FULL_SCALE, 32'h0000_07d0);
    chk("scale run", resp, RESP_OKAY);
    repeat (1000) @(posedge clk);
    chk("pulse scaled", ref_out.freq_ref, 16'h09c4);
    wr(OFF_FULL_SCALE, 32'h0000_03e8);
    half <= 8'h01;
    repeat (1000) @(posedge clk);
    chk("pulse sat", ref_out.freq_ref, REF_FULL);
    rdr(OFF_PULSE_HZ);
    chk("pulse hz", rd, 32'h2710_07d0);
    drive_running <= 1'b0;
    wr(OFF_PULSE_FN, 32'h0000_0001);
    look(16'h0000);
    chk("pid fb", ref_out.pid_feedback, REF_FULL);
    wr(OFF_PULSE_FN, 32'h0000_0002);
    look(16'h0000);
    chk("pid sp", ref_out.pid_target, REF_FULL);
    chk("pid fb off", ref_out.pid_feedback, 16'h0000);
    $display("test pulse done");
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    chk("reset out", ref_out.pid_target, 16'h0000);
    rst_n <= 1'b1;
    @(posedge clk);
    rdr(OFF_PULSE_FN);
    chk("fn rerun reset", rd, 32'h0000_0000);
    $display("test rerun reset done");
    finish_test;
  end
endmodule // freq_ref_selector_test
